// ### contact_edge.sv
// edge detector for the run/stop contact (1 = closed = run)
// assumes the contact is already synchronous and debounced
module contact_edge (
  // clock and reset
  input  wire logic clock,
  input  wire logic rst,
  // contact
  input  wire logic level,
  input  wire logic enable,
  output logic      opened,
  output logic      closed
);
  logic prev_r;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) prev_r <= 1'b1;
    else     prev_r <= enable ? level : 1'b1;
  end
  assign opened = enable & prev_r & ~level;
  assign closed = enable & ~prev_r & level;
endmodule : contact_edge

// ### group_run_stop_coordinator.sv
// group run/stop coordinator for peer controllers on a shared link
// assumes link messages arrive as one-cycle strobes, synchronous to clock
// What this block does
// - contact assignment setting ranges 1..25, default 1
// - with link and contacts present, assignment limited to 11..25, default 11
// - first contact is run/stop only for 12,13,14,16,17,18,22
// - contact-driven group run/stop only on link-plus-contact variants
// - group number ranges 0..16, default 0
// - group 0 neither sends nor follows group run/stop
// - one minute without keys while editing discards the edit
// - edited value stored only on confirm key
// - key stop on any member stops the whole group unless key run is set in the same write or that member's contact closes in the same cycle
// - key run on any member runs group unless contact stop holds or that member's contact closes in the same cycle
// - contact closed to open stops the whole group
// - contact open to closed runs the whole group unless a key stop or another contact stop holds
// - group stays stopped while causing contact still says stop
// - contact stop shows a distinct indication naming its source
// - key propagation identical with or without contacts except in a contact edge cycle, where only the contact message is sent
// - contact stop on key-stopped group only changes indication
// - leaving combined stop needs contact run and key run
// - contact and key requests disagreeing gives stop
// - link serves at most 32 controllers
// - device address 0..31, default 0
module group_run_stop_coordinator
  import grp_pkg::*;
#(
  parameter bit          HAS_LINK    = 1'b1,
  parameter bit          HAS_CONTACT = 1'b1,
  parameter int unsigned TIMEOUT     = EDIT_TIMEOUT_CY
) (
  // clock and reset
  input  wire logic       clock,
  input  wire logic       rst,
  // register port
  input  wire logic [3:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  output logic [7:0]      rdata,
  // contact input, 1 = closed = run
  input  wire logic       first_contact_input,
  // link receive
  input  wire logic       rx_valid,
  input  wire logic [4:0] rx_group,
  input  wire logic [4:0] rx_src,
  input  wire logic       rx_run,
  input  wire logic       rx_contact,
  // link transmit
  output logic            tx_valid,
  output logic [4:0]      tx_group,
  output logic [4:0]      tx_src,
  output logic            tx_run,
  output logic            tx_contact,
  // state
  output logic            running,
  output logic            contact_stop_indication,
  output logic [1:0]      stop_indication,
  output logic            monitor_return
);
  initial begin
    if (MAX_PEERS > 32 || TIMEOUT < 1)
      $error("group_run_stop_coordinator: bad parameters");
  end

  // assignment floor depends on variant
  localparam logic [4:0] A_MIN =
    (HAS_LINK && HAS_CONTACT) ? ASSIGN_MIN_COMM : ASSIGN_MIN;

  function automatic logic is_runstop(input logic [4:0] a);
    case (a)
      5'h0c, 5'h0d, 5'h0e, 5'h10, 5'h11, 5'h12, 5'h16: is_runstop = 1'b1;
      default: is_runstop = 1'b0;
    endcase
  endfunction : is_runstop

  logic [4:0] assign_v;
  logic [4:0] group_v;
  logic [4:0] addr_r;
  logic       ed_on_a;
  logic       ed_on_g;
  logic       to_a;
  logic       to_g;
  logic       k_up;
  logic       k_dn;
  logic       k_set;
  logic       k_sel;
  logic       key_wr;

  assign key_wr = wr && addr == REG_KEYS;
  assign k_up   = key_wr & wdata[KEY_UP];
  assign k_dn   = key_wr & wdata[KEY_DOWN];
  assign k_set  = key_wr & wdata[KEY_SET];
  assign k_sel  = wdata[KEY_SEL_GRP];

  setting_editor #(
    .MIN_V   (A_MIN),
    .MAX_V   (ASSIGN_MAX),
    .DEF_V   ((HAS_LINK && HAS_CONTACT) ? ASSIGN_MIN_COMM : ASSIGN_DEFAULT),
    .TIMEOUT (TIMEOUT)
  ) u_assign_ed (
    .clock     (clock),
    .rst       (rst),
    .sel       (~k_sel),
    .up        (k_up),
    .down      (k_dn),
    .confirm   (k_set),
    .value     (assign_v),
    .editing   (ed_on_a),
    .timed_out (to_a)
  );

  setting_editor #(
    .MIN_V   (GROUP_DEFAULT),
    .MAX_V   (GROUP_MAX),
    .DEF_V   (GROUP_DEFAULT),
    .TIMEOUT (TIMEOUT)
  ) u_group_ed (
    .clock     (clock),
    .rst       (rst),
    .sel       (k_sel),
    .up        (k_up),
    .down      (k_dn),
    .confirm   (k_set),
    .value     (group_v),
    .editing   (ed_on_g),
    .timed_out (to_g)
  );

  assign monitor_return = to_a | to_g;

  // device address register
  always_ff @(posedge clock or posedge rst) begin
    if (rst) addr_r <= ADDR_DEFAULT;
    // compare the whole byte so that 32 and above are refused, not wrapped
    else if (wr && addr == REG_ADDR && wdata <= {3'h0, ADDR_MAX})
      addr_r <= wdata[4:0];
  end

  // derived enables
  logic in_group;
  logic di_on;
  logic member;
  assign in_group = group_v != GROUP_DEFAULT;
  assign di_on = HAS_LINK && HAS_CONTACT && is_runstop(assign_v);
  assign member = rx_valid && in_group && rx_group == group_v;

  logic c_open;
  logic c_close;
  contact_edge u_edge (
    .clock  (clock),
    .rst    (rst),
    .level  (first_contact_input),
    .enable (di_on),
    .opened (c_open),
    .closed (c_close)
  );

  // local key commands
  logic key_run;
  logic key_stop;
  assign key_run  = wr && addr == REG_KEYS && wdata[KEY_RUN];
  assign key_stop = wr && addr == REG_KEYS && wdata[KEY_STOP] && !key_run;

  // key request is shared by the group; contact holds tracked per source
  logic        key_req_r;
  logic [31:0] hold_r;
  logic        local_hold;
  logic        remote_hold;
  assign local_hold = di_on && !first_contact_input;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) key_req_r <= 1'b1;
    else if (key_stop) key_req_r <= 1'b0;
    else if (key_run) key_req_r <= 1'b1;
    else if (member && !rx_contact) key_req_r <= rx_run;
  end

  // remote contact holds; a source that reopens is cleared by its close
  always_ff @(posedge clock or posedge rst) begin
    if (rst) hold_r <= '0;
    else if (!in_group) hold_r <= '0;
    else if (member && rx_contact)
      hold_r[rx_src] <= !rx_run;
  end
  assign remote_hold = |hold_r;

  // contact close releases only the contact; key request untouched
  // even when the close is the only stop cause, which lets the group run
  logic run_nxt;
  always_comb begin
    run_nxt = key_req_r && !local_hold && !remote_hold;
  end

  logic running_r;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) running_r <= 1'b0;
    else running_r <= run_nxt;
  end
  assign running = running_r;

  // stop indication: key, own contact, or another member's contact
  stop_ind_e ind_r;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) ind_r <= IND_KEY;
    else if (run_nxt) ind_r <= IND_NONE;
    else if (local_hold) ind_r <= IND_CONTACT;
    else if (remote_hold) ind_r <= IND_GROUP;
    else ind_r <= IND_KEY;
  end
  assign stop_indication = ind_r;
  assign contact_stop_indication = ind_r == IND_CONTACT;

  // outbound messages, suppressed for group 0
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      tx_valid   <= 1'b0;
      tx_group   <= '0;
      tx_src     <= '0;
      tx_run     <= 1'b0;
      tx_contact <= 1'b0;
    end else begin
      tx_valid   <= in_group && (key_run || key_stop || c_open || c_close);
      tx_group   <= group_v;
      tx_src     <= addr_r;
      tx_contact <= c_open || c_close;
      tx_run     <= (c_open || c_close) ? c_close : key_run;
    end
  end

  // register read port
  always_ff @(posedge clock or posedge rst) begin
    if (rst) rdata <= '0;
    else if (rd) begin
      case (addr)
        REG_ASSIGN: rdata <= {3'h0, assign_v};
        REG_GROUP:  rdata <= {3'h0, group_v};
        REG_ADDR:   rdata <= {3'h0, addr_r};
        REG_STATUS: rdata <= {ed_on_g, ed_on_a, di_on, key_req_r,
                              remote_hold, ind_r, running_r};
        default:    rdata <= '0;
      endcase
    end else rdata <= '0;
  end
endmodule : group_run_stop_coordinator

// ### grp_assertions.sv
// port checker for the group run/stop coordinator
// assumes a bind onto the coordinator, one clock, async reset
module grp_checker
  import grp_pkg::*;
(
  // clock and reset
  input wire logic       clock,
  input wire logic       rst,
  // register port
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       wr,
  // link transmit
  input wire logic       tx_valid,
  input wire logic [4:0] tx_group,
  input wire logic       tx_run,
  input wire logic       tx_contact,
  // state
  input wire logic       running,
  input wire logic       contact_stop_indication,
  input wire logic [1:0] stop_indication,
  input wire logic       monitor_return
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);
  logic krun;
  logic kstop;
  assign krun = wr && addr == REG_KEYS && wdata[KEY_RUN] && !wdata[KEY_STOP];
  assign kstop = wr && addr == REG_KEYS && wdata[KEY_STOP] && !wdata[KEY_RUN];
  chk_ind_tie: assert property (
    contact_stop_indication == (stop_indication == IND_CONTACT))
    else $error("contact indication out of step");
  chk_tx_group: assert property (
    tx_valid |-> tx_group != 5'h00 && tx_group <= GROUP_MAX)
    else $error("message sent outside a group");
  chk_key_stop: assert property (kstop |-> ##2 !running)
    else $error("key stop did not stop");
  chk_key_run: assert property (
    krun |-> ##2 running || stop_indication[1])
    else $error("key run did not run");
  chk_tx_stop: assert property (
    tx_valid && !tx_run && !tx_contact |=> !running)
    else $error("sent stop but still running");
  chk_run_clear: assert property (
    running |-> stop_indication == IND_NONE)
    else $error("running with a stop indication");
  chk_contact_hold: assert property (
    stop_indication[1] |-> !running)
    else $error("running under contact stop");
  chk_mon_pulse: assert property (
    monitor_return |=> !monitor_return)
    else $error("monitor return longer than a pulse");
  cover property (contact_stop_indication);
  cover property (stop_indication == IND_GROUP);
  cover property (monitor_return);
endmodule : grp_checker

// ### grp_pkg.sv
// shared constants for the group run/stop coordinator
// assumes a 10 MHz system clock and a synchronous link message port
package grp_pkg;
  localparam int unsigned CLK_HZ          = 10_000_000;
  localparam int unsigned EDIT_TIMEOUT_S  = 60;
  localparam int unsigned EDIT_TIMEOUT_CY = EDIT_TIMEOUT_S * CLK_HZ;
  localparam logic [4:0] ASSIGN_MIN       = 5'h01;
  localparam logic [4:0] ASSIGN_MAX       = 5'h19;
  localparam logic [4:0] ASSIGN_MIN_COMM  = 5'h0b;
  localparam logic [4:0] ASSIGN_DEFAULT   = 5'h01;
  localparam logic [4:0] GROUP_MAX        = 5'h10;
  localparam logic [4:0] GROUP_DEFAULT    = 5'h00;
  localparam logic [4:0] ADDR_MAX         = 5'h1f;
  localparam logic [4:0] ADDR_DEFAULT     = 5'h00;
  localparam int unsigned MAX_PEERS       = 32;
  // register map, word index in low address bits
  localparam logic [3:0] REG_ASSIGN = 4'h0;
  localparam logic [3:0] REG_GROUP  = 4'h1;
  localparam logic [3:0] REG_ADDR   = 4'h2;
  localparam logic [3:0] REG_STATUS = 4'h3;
  localparam logic [3:0] REG_KEYS   = 4'h4;
  // key command word bits
  localparam int KEY_UP      = 0;
  localparam int KEY_DOWN    = 1;
  localparam int KEY_SET     = 2;
  localparam int KEY_RUN     = 3;
  localparam int KEY_STOP    = 4;
  localparam int KEY_SEL_GRP = 5;
  typedef enum logic [1:0] {IND_NONE, IND_KEY, IND_CONTACT, IND_GROUP}
    stop_ind_e;
endpackage : grp_pkg

// ### peer_model.sv
// behavioural peer controller on the link
// assumes one-cycle message strobes on the coordinator clock
module peer_model
  import grp_pkg::*;
#(
  parameter logic [4:0] SRC = 5'h03
) (
  // clock and reset
  input  wire logic       clock,
  input  wire logic       rst,
  // toward the coordinator
  output logic            rx_valid,
  output logic [4:0]      rx_group,
  output logic [4:0]      rx_src,
  output logic            rx_run,
  output logic            rx_contact,
  // from the coordinator
  input  wire logic       tx_valid,
  input  wire logic [4:0] tx_group,
  input  wire logic [4:0] tx_src,
  input  wire logic       tx_run,
  input  wire logic       tx_contact
);
  timeunit 1ns;
  timeprecision 1ns;
  logic       go = 1'b0;
  logic [6:0] msg;
  logic [6:0] seen = 7'h00;
  logic [4:0] src_seen = 5'h00;
  int         tx_n = 0;
  task automatic send(input logic [4:0] g, input logic r, input logic c);
    @(negedge clock);
    msg = {g, r, c};
    go = 1'b1;
    @(posedge clock);
    #1;
  endtask : send
  // idle fields flip so stale data never looks like a message
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      rx_valid <= 1'b0;
      {rx_group, rx_run, rx_contact, rx_src} <= 12'h000;
    end else if (go) begin
      rx_valid <= 1'b1;
      {rx_group, rx_run, rx_contact, rx_src} <= {msg, SRC};
      go = 1'b0;
    end else begin
      rx_valid <= 1'b0;
      {rx_group, rx_run, rx_contact, rx_src} <=
        ~{rx_group, rx_run, rx_contact, rx_src};
    end
  end
  always @(posedge clock) begin
    if (tx_valid) begin
      tx_n <= tx_n + 1;
      seen <= {tx_group, tx_run, tx_contact};
      src_seen <= tx_src;
    end
  end
endmodule : peer_model

// ### setting_editor.sv
// edits one numeric setting with up/down/confirm and a 1 minute timeout
// assumes key pulses are one cycle wide and synchronous
module setting_editor
  import grp_pkg::*;
#(
  parameter logic [4:0] MIN_V   = 5'h00,
  parameter logic [4:0] MAX_V   = 5'h10,
  parameter logic [4:0] DEF_V   = 5'h00,
  parameter int unsigned TIMEOUT = EDIT_TIMEOUT_CY
) (
  // clock and reset
  input  wire logic       clock,
  input  wire logic       rst,
  // keys
  input  wire logic       sel,
  input  wire logic       up,
  input  wire logic       down,
  input  wire logic       confirm,
  // result
  output logic [4:0]      value,
  output logic            editing,
  output logic            timed_out
);
  initial begin
    if (MIN_V > MAX_V || DEF_V < MIN_V || DEF_V > MAX_V || TIMEOUT < 1)
      $error("setting_editor: bad parameters");
  end

  logic [4:0]  stored_r;
  logic [4:0]  pend_r;
  logic        edit_r;
  logic [31:0] idle_r;
  logic        to_r;
  logic        act;

  assign act = sel & (up | down | confirm);
  assign value = stored_r;
  assign editing = edit_r;
  assign timed_out = to_r;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      stored_r <= DEF_V;
      pend_r   <= DEF_V;
      edit_r   <= 1'b0;
      idle_r   <= '0;
      to_r     <= 1'b0;
    end else begin
      to_r <= 1'b0;
      if (act) idle_r <= '0;
      if (sel && confirm) begin
        if (edit_r) stored_r <= pend_r;
        edit_r <= 1'b0;
      end else if (sel && up) begin
        pend_r <= (edit_r ? pend_r : stored_r) == MAX_V ? MAX_V :
                  (edit_r ? pend_r : stored_r) + 5'h01;
        edit_r <= 1'b1;
      end else if (sel && down) begin
        pend_r <= (edit_r ? pend_r : stored_r) == MIN_V ? MIN_V :
                  (edit_r ? pend_r : stored_r) - 5'h01;
        edit_r <= 1'b1;
      end else if (edit_r) begin
        // old value kept; edit abandoned
        if (idle_r >= TIMEOUT - 1) begin
          edit_r <= 1'b0;
          to_r   <= 1'b1;
          idle_r <= '0;
        end else begin
          idle_r <= idle_r + 32'h0000_0001;
        end
      end
    end
  end
endmodule : setting_editor

// ### tb_top.sv
// testbench for the group run/stop coordinator
// assumes grp_pkg, peer_model and grp_checker compiled first
module tb_top
  import grp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clock = 1'b0;
  logic       rst = 1'b1;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic       wr = 1'b0;
  logic       rd = 1'b0;
  logic       first_contact_input = 1'b1;
  logic [7:0] rdata;
  logic       rx_valid, rx_run, rx_contact;
  logic [4:0] rx_group, rx_src, tx_group, tx_src;
  logic       tx_valid, tx_run, tx_contact, running;
  logic       contact_stop_indication, monitor_return;
  logic [1:0] stop_indication;
  int         err_total = 0;
  int         cmp_count = 0;
  int         cyc = 0;
  int         mon_n = 0;
  // short timeout keeps the edit test fast
  group_run_stop_coordinator #(.TIMEOUT(20)) u_dut (.*);
  peer_model u_peer (.*);
  initial forever #50 clock = ~clock;
  always @(posedge clock) begin
    cyc++;
    mon_n += int'(monitor_return === 1'b1);
    if (cyc == 3000) begin
      err_total++;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish();
    if (err_total == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : tally_and_finish
  task automatic chk(input string n, input logic [7:0] s, e);
    cmp_count++;
    if (s !== e) begin
      err_total++;
      $display("CHECK FAILED %s exp %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic wreg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask : wreg
  task automatic rreg(input logic [3:0] a, input logic [7:0] e);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1;
    chk("rdata", rdata, e);
  endtask : rreg
  task automatic key(input logic [7:0] d);
    wreg(REG_KEYS, d);
  endtask : key
  task automatic dic(input logic v);
    @(posedge clock);
    first_contact_input <= v;
  endtask : dic
  task automatic st(input logic r, input logic [1:0] i);
    repeat (4) @(posedge clock);
    #1;
    chk("running", {7'h00, running}, {7'h00, r});
    chk("stop_ind", {6'h00, stop_indication}, {6'h00, i});
  endtask : st
  initial begin
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    rreg(REG_ASSIGN, 8'h0b);
    rreg(REG_GROUP, 8'h00);
    rreg(REG_ADDR, 8'h00);
    rreg(4'hf, 8'h00);
    wreg(REG_ADDR, 8'h1f);
    wreg(REG_ADDR, 8'h20);
    rreg(REG_ADDR, 8'h1f);
    key(8'h10);
    st(0, IND_KEY);
    chk("tx_n", 8'(u_peer.tx_n), 8'h00);
    u_peer.send(5'h01, 1'b1, 1'b0);
    st(0, IND_KEY);
    key(8'h01);
    rreg(REG_ASSIGN, 8'h0b);
    key(8'h04);
    rreg(REG_ASSIGN, 8'h0c);
    key(8'h21);
    repeat (30) @(posedge clock);
    chk("monitor", 8'(mon_n), 8'h01);
    rreg(REG_GROUP, 8'h00);
    key(8'h21);
    key(8'h24);
    rreg(REG_GROUP, 8'h01);
    key(8'h08);
    st(1, IND_NONE);
    chk("tx", {1'b0, u_peer.seen}, 8'h06);
    chk("tx_src", {3'h0, u_peer.src_seen}, 8'h1f);
    key(8'h10);
    st(0, IND_KEY);
    u_peer.send(5'h01, 1'b1, 1'b0);
    st(1, IND_NONE);
    u_peer.send(5'h02, 1'b0, 1'b0);
    st(1, IND_NONE);
    dic(1'b0);
    st(0, IND_CONTACT);
    chk("tx", {1'b0, u_peer.seen}, 8'h05);
    key(8'h08);
    st(0, IND_CONTACT);
    dic(1'b1);
    st(1, IND_NONE);
    key(8'h10);
    dic(1'b0);
    st(0, IND_CONTACT);
    dic(1'b1);
    st(0, IND_KEY);
    key(8'h08);
    st(1, IND_NONE);
    u_peer.send(5'h01, 1'b0, 1'b1);
    st(0, IND_GROUP);
    key(8'h08);
    st(0, IND_GROUP);
    u_peer.send(5'h01, 1'b1, 1'b1);
    st(1, IND_NONE);
    rreg(REG_STATUS, 8'h31);
    tally_and_finish();
  end
endmodule : tb_top
bind group_run_stop_coordinator grp_checker u_chk (
  .clock, .rst, .addr, .wdata, .wr, .tx_valid, .tx_group, .tx_run,
  .tx_contact, .running, .contact_stop_indication, .stop_indication,
  .monitor_return
);
